//--- hw/counter_array_watchdog_pkg.sv
// constants and state type of the counter array watchdog
package counter_array_watchdog_pkg;

	// ======================================================================
	// register byte offsets (one 32-bit word each)
	localparam logic [7:0] OFF_MODE     = 8'h00;
	localparam logic [7:0] OFF_CTRL     = 8'h04;
	localparam logic [7:0] OFF_CNT_LOW  = 8'h08;
	localparam logic [7:0] OFF_CNT_HIGH = 8'h0c;
	localparam logic [7:0] OFF_M4_MODE  = 8'h10;
	localparam logic [7:0] OFF_M4_LOW   = 8'h14;
	localparam logic [7:0] OFF_M4_HIGH  = 8'h18;
	localparam logic [7:0] OFF_STATUS   = 8'h1c;
	localparam logic [7:0] OFF_MASK     = 8'h20;

	// ======================================================================
	// field positions
	localparam int MODE_IDLE_BIT  = 7;
	localparam int MODE_WDE_BIT   = 6;
	localparam int MODE_CLK_LSB   = 1;
	localparam int CTRL_RUN_BIT   = 0;
	localparam int EV_OVERFLOW    = 0;
	localparam int EV_WD_FIRE     = 1;
	localparam int EV_SERVICE     = 2;
	localparam int EV_COUNT       = 3;

	// ======================================================================
	// encodings and counts
	localparam logic [2:0] CLK_DIV12    = 3'h0;
	localparam logic [2:0] CLK_DIV4     = 3'h1;
	localparam logic [2:0] CLK_EXTERNAL = 3'h2;
	localparam logic [3:0] DIV_LAST     = 4'hb;
	localparam logic [7:0] SW_TIMER_MODE = 8'h48;
	localparam logic       WD_ENABLE_RESET = 1'b1;

	// ======================================================================
	// whole module state
	typedef struct packed {
		logic [7:0]          counterLow;
		logic [7:0]          counterHigh;
		logic [7:0]          modFourMode;
		logic [7:0]          offsetLow;
		logic [7:0]          compareHigh;
		logic                wdEnable;
		logic                idleHalt;
		logic [2:0]          clkSel;
		logic                runCtl;
		logic [3:0]          divider;
		logic [2:0]          extSync;
		logic                extLevel;
		logic [EV_COUNT-1:0] irqStatus;
		logic [EV_COUNT-1:0] irqMask;
		logic                ack;
		logic [31:0]         rdata;
		logic                wdReset;
	} state_t;

	localparam state_t STATE_RESET = '{wdEnable: WD_ENABLE_RESET, default: '0};

endpackage : counter_array_watchdog_pkg

//--- hw/counter_array_watchdog.sv
// counter array with its module four watchdog, wishbone register slave
//
// Design decisions made here: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
module counter_array_watchdog
	import counter_array_watchdog_pkg::*;
(
	// clock and reset
	input  wire logic        clock,
	input  wire logic        rst_n,
	// wishbone classic slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	// core and pin side
	input  wire logic        extClockPin,
	input  wire logic        idleMode,
	output logic             watchdogReset,
	output logic             counterRunning,
	output logic             irq
);

	// ======================================================================
	// helpers
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
		return addr == off;
	endfunction : hit

	state_t               s;
	state_t               n;
	logic                 commit;
	logic                 tick;
	logic                 running;
	logic                 wrapMatch;
	logic                 lowCarry;
	logic [7:0]           serviceValue;
	logic [7:0]           modeView;
	logic [31:0]          readValue;
	logic [EV_COUNT-1:0]  events;
	logic [EV_COUNT-1:0]  clearBits;

	// a write lands only on the edge where the master sees ack
	assign commit = cyc_i & stb_i & we_i & s.ack & sel_i[0];

	// ======================================================================
	// counter timebase
	always_comb
	begin
		case (s.clkSel)
			CLK_DIV12:    tick = s.divider == DIV_LAST;
			CLK_DIV4:     tick = s.divider[1:0] == 2'h3;
			CLK_EXTERNAL: tick = (s.extSync[1] == s.extSync[2]) & s.extSync[2] & ~s.extLevel;
			default:      tick = 1'b1;
		endcase
	end

	// idle halt still applies; only the run bit is overridden
	assign running = (s.runCtl | s.wdEnable) & ~(s.idleHalt & idleMode);
	assign wrapMatch = s.wdEnable & running & tick & (s.counterLow == 8'hff)
		& ((s.counterHigh + 8'h01) == s.compareHigh);
	assign serviceValue = s.counterHigh + s.offsetLow;
	// carry into the high byte, read by the high byte lock check below
	assign lowCarry = running & tick & (s.counterLow == 8'hff);

	assign modeView = {s.idleHalt, s.wdEnable, 2'b00, s.clkSel, 1'b0};

	// ======================================================================
	// register read decode
	always_comb
	begin
		readValue = 32'h0000_0000;
		if (hit(adr_i, OFF_MODE))
			readValue[7:0] = modeView;
		else if (hit(adr_i, OFF_CTRL))
			readValue[CTRL_RUN_BIT] = s.runCtl;
		else if (hit(adr_i, OFF_CNT_LOW))
			readValue[7:0] = s.counterLow;
		else if (hit(adr_i, OFF_CNT_HIGH))
			readValue[7:0] = s.counterHigh;
		else if (hit(adr_i, OFF_M4_MODE))
			readValue[7:0] = s.modFourMode;
		else if (hit(adr_i, OFF_M4_LOW))
			readValue[7:0] = s.offsetLow;
		else if (hit(adr_i, OFF_M4_HIGH))
			readValue[7:0] = s.compareHigh;
		else if (hit(adr_i, OFF_STATUS))
			readValue[EV_COUNT-1:0] = s.irqStatus;
		else if (hit(adr_i, OFF_MASK))
			readValue[EV_COUNT-1:0] = s.irqMask;
	end

	// ======================================================================
	// events and interrupt flags
	always_comb
	begin
		events = '0;
		events[EV_OVERFLOW] = running & tick & ({s.counterHigh, s.counterLow} == 16'hffff);
		events[EV_WD_FIRE] = wrapMatch;
		events[EV_SERVICE] = commit & s.wdEnable & hit(adr_i, OFF_M4_HIGH);
		clearBits = '0;
		if (commit && hit(adr_i, OFF_STATUS))
			clearBits = dat_i[EV_COUNT-1:0];
	end

	// ======================================================================
	// next state
	always_comb
	begin
		n = s;
		n.extSync = {s.extSync[1:0], extClockPin};
		// the level moves only once the two late stages agree
		if (s.extSync[1] == s.extSync[2])
			n.extLevel = s.extSync[2];
		n.divider = (s.divider == DIV_LAST) ? 4'h0 : s.divider + 4'h1;
		n.ack = cyc_i & stb_i & ~s.ack;
		n.rdata = readValue;
		n.wdReset = wrapMatch;
		if (running && tick)
			{n.counterHigh, n.counterLow} = {s.counterHigh, s.counterLow} + 16'h0001;
		if (s.wdEnable)
			n.modFourMode = SW_TIMER_MODE;
		if (commit)
		begin
			if (hit(adr_i, OFF_MODE))
			begin
				n.wdEnable = dat_i[MODE_WDE_BIT];
				if (!s.wdEnable)
				begin
					n.idleHalt = dat_i[MODE_IDLE_BIT];
					n.clkSel = dat_i[MODE_CLK_LSB +: 3];
				end
			end
			else if (hit(adr_i, OFF_CTRL))
				n.runCtl = dat_i[CTRL_RUN_BIT];
			else if (hit(adr_i, OFF_CNT_LOW) && !s.wdEnable)
				n.counterLow = dat_i[7:0];
			else if (hit(adr_i, OFF_CNT_HIGH) && !s.wdEnable)
				n.counterHigh = dat_i[7:0];
			else if (hit(adr_i, OFF_M4_MODE) && !s.wdEnable)
				n.modFourMode = dat_i[7:0];
			else if (hit(adr_i, OFF_M4_LOW))
				n.offsetLow = dat_i[7:0];
			else if (hit(adr_i, OFF_M4_HIGH))
				n.compareHigh = s.wdEnable ? serviceValue : dat_i[7:0];
			else if (hit(adr_i, OFF_MASK))
				n.irqMask = dat_i[EV_COUNT-1:0];
		end
		// a new event beats a clear in the same cycle
		n.irqStatus = (s.irqStatus & ~clearBits) | events;
	end

	// enable bit returns set with every reset of the device
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			s <= STATE_RESET;
		else
			s <= n;
	end

	assign dat_o = s.rdata;
	assign ack_o = s.ack;
	assign watchdogReset = s.wdReset;
	assign counterRunning = running;
	assign irq = |(s.irqStatus & s.irqMask);

	// ======================================================================
	// assertions
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	property p_match_fires;
		wrapMatch |=> watchdogReset && s.irqStatus[EV_WD_FIRE];
	endproperty
	a_match_fires: assert property (p_match_fires) else $error("match gave no reset");

	property p_fire_needs_enable;
		watchdogReset |-> $past(s.wdEnable) && $past(s.compareHigh) == s.counterHigh;
	endproperty
	a_fire_needs_enable: assert property (p_fire_needs_enable) else $error("stray reset");

	property p_service_reload;
		commit && s.wdEnable && hit(adr_i, OFF_M4_HIGH)
			|=> s.compareHigh == $past(s.counterHigh) + $past(s.offsetLow);
	endproperty
	a_service_reload: assert property (p_service_reload) else $error("bad reload");

	property p_forced_run;
		s.wdEnable && !(s.idleHalt && idleMode) && tick |=> s.counterLow != $past(s.counterLow);
	endproperty
	a_forced_run: assert property (p_forced_run) else $error("counter stalled");

	property p_counter_locked;
		commit && s.wdEnable && hit(adr_i, OFF_CNT_LOW)
			|=> s.counterLow == $past(s.counterLow) + {7'h00, $past(running) & $past(tick)};
	endproperty
	a_counter_locked: assert property (p_counter_locked) else $error("counter written");

	property p_clk_frozen;
		s.wdEnable |=> $stable(s.clkSel) && $stable(s.idleHalt);
	endproperty
	a_clk_frozen: assert property (p_clk_frozen) else $error("frozen field moved");

	property p_sw_timer;
		s.wdEnable ##1 s.wdEnable |-> s.modFourMode == SW_TIMER_MODE;
	endproperty
	a_sw_timer: assert property (p_sw_timer) else $error("module four not forced");

	property p_run_readback;
		ack_o && !we_i && hit(adr_i, OFF_CTRL) && !s.runCtl |-> dat_o[CTRL_RUN_BIT] == 1'b0;
	endproperty
	a_run_readback: assert property (p_run_readback) else $error("run bit reads one");

	property p_unlocked_write;
		commit && !s.wdEnable && hit(adr_i, OFF_CNT_HIGH) |=> s.counterHigh == $past(dat_i[7:0]);
	endproperty
	a_unlocked_write: assert property (p_unlocked_write) else $error("write lost");

	property p_enable_write;
		commit && hit(adr_i, OFF_MODE) |=> s.wdEnable == $past(dat_i[MODE_WDE_BIT]);
	endproperty
	a_enable_write: assert property (p_enable_write) else $error("enable not taken");

	// ======================================================================
	// lock and flag checks
	// a locked write may still see the counter step underneath it
	property p_high_locked;
		commit && s.wdEnable && hit(adr_i, OFF_CNT_HIGH)
			|=> s.counterHigh == $past(s.counterHigh) + {7'h00, $past(lowCarry)};
	endproperty
	a_high_locked: assert property (p_high_locked) else $error("high written");

	property p_mode_locked;
		commit && s.wdEnable && hit(adr_i, OFF_M4_MODE) |=> s.modFourMode == SW_TIMER_MODE;
	endproperty
	a_mode_locked: assert property (p_mode_locked) else $error("mode write taken");

	property p_offset_write;
		commit && hit(adr_i, OFF_M4_LOW) |=> s.offsetLow == $past(dat_i[7:0]);
	endproperty
	a_offset_write: assert property (p_offset_write) else $error("offset lost");

	property p_run_kept;
		commit && s.wdEnable && hit(adr_i, OFF_CTRL)
			|=> s.wdEnable && (counterRunning || (s.idleHalt && idleMode));
	endproperty
	a_run_kept: assert property (p_run_kept) else $error("run write stopped counter");

	property p_run_stored;
		commit && hit(adr_i, OFF_CTRL) |=> s.runCtl == $past(dat_i[CTRL_RUN_BIT]);
	endproperty
	a_run_stored: assert property (p_run_stored) else $error("run bit lost");

	property p_ack_pulse;
		ack_o |=> !ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");

	property p_fire_pulse;
		watchdogReset |=> !watchdogReset;
	endproperty
	a_fire_pulse: assert property (p_fire_pulse) else $error("reset held");

	property p_fire_sticky;
		s.irqStatus[EV_WD_FIRE] && !(commit && hit(adr_i, OFF_STATUS) && dat_i[EV_WD_FIRE])
			|=> s.irqStatus[EV_WD_FIRE];
	endproperty
	a_fire_sticky: assert property (p_fire_sticky) else $error("fire flag lost");

	property p_select_released;
		commit && !s.wdEnable && hit(adr_i, OFF_MODE)
			|=> s.clkSel == $past(dat_i[MODE_CLK_LSB +: 3])
			&& s.idleHalt == $past(dat_i[MODE_IDLE_BIT]);
	endproperty
	a_select_released: assert property (p_select_released) else $error("select lost");

	property p_service_flag;
		commit && s.wdEnable && hit(adr_i, OFF_M4_HIGH) |=> s.irqStatus[EV_SERVICE];
	endproperty
	a_service_flag: assert property (p_service_flag) else $error("service not flagged");

	property p_no_fire_disabled;
		!s.wdEnable |=> !watchdogReset;
	endproperty
	a_no_fire_disabled: assert property (p_no_fire_disabled) else $error("fired disabled");

endmodule : counter_array_watchdog

//--- bench/tb_top.sv
// self-checking bench for the counter array watchdog
`timescale 1ns/1ps
module tb_top
	import counter_array_watchdog_pkg::*;
;
	// ======================================================================
	// signals
	logic        clock, rst_n, cyc, stb, we, extPin, idle;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] dat, datOut, rnd;
	logic        ack, wdRst, running, irq;
	logic [7:0]  expQ[$];
	int          numErrors, checked, fires;

	counter_array_watchdog uut (.clock(clock), .rst_n(rst_n), .cyc_i(cyc), .stb_i(stb),
		.we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(datOut), .ack_o(ack),
		.extClockPin(extPin), .idleMode(idle), .watchdogReset(wdRst),
		.counterRunning(running), .irq(irq));

	// ======================================================================
	// helpers
	function automatic logic [31:0] lfsrNext(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsrNext

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			numErrors++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// one classic cycle; read expectations go to the queue for the monitor
	task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		sel <= 4'hf;
		adr <= a;
		dat <= {24'h0, d};
		do
		begin
			@(posedge clock);
			n++;
		end
		while (ack !== 1'b1 && n < 50);
		if (n >= 50)
			check("ack", 1'b0, 1'b1);
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clock);
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(a, 1'b1, d);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		expQ.push_back(e);
		bus(a, 1'b0, 8'h00);
	endtask : rd

	// levels are looked at mid-cycle; the bench then returns to a rising edge
	task automatic lvl(input string name, input logic isIrq, input logic exp);
		repeat (2) @(negedge clock);
		check(name, isIrq ? irq : running, exp);
		@(posedge clock);
	endtask : lvl

	task automatic tally_and_finish();
		$display("checked %0d mismatches %0d", checked, numErrors);
		if (numErrors == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : tally_and_finish

	// ======================================================================
	// clock, monitor and watchdog
	initial
	begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	always @(posedge clock)
	begin
		if (wdRst === 1'b1)
			fires++;
		if (ack === 1'b1 && we === 1'b0 && expQ.size() > 0)
			check("read data", datOut, {24'h0, expQ.pop_front()});
	end

	initial
	begin
		repeat (20000) @(posedge clock);
		numErrors++;
		tally_and_finish();
	end

	// ======================================================================
	// tests
	initial
	begin
		{cyc, stb, we, adr, dat, extPin, idle, fires} = '0;
		sel = 4'hf;
		rnd = 32'h1315;
		rst_n = 1'b0;
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		// enabled out of reset: locks hold
		rd(OFF_MODE, 8'h40);
		wr(OFF_MODE, 8'hc6);
		rd(OFF_MODE, 8'h40);
		wr(OFF_M4_MODE, 8'h00);
		rd(OFF_M4_MODE, SW_TIMER_MODE);
		wr(OFF_CTRL, 8'h00);
		lvl("running", 1'b0, 1'b1);
		rd(OFF_CTRL, 8'h00);
		wr(OFF_CTRL, 8'h01);
		rd(OFF_CTRL, 8'h01);
		wr(OFF_CTRL, 8'h00);
		rd(8'h24, 8'h00);
		$display("test locks done");
		// disabling hands the controls back
		wr(OFF_MODE, 8'h00);
		rd(OFF_MODE, 8'h00);
		lvl("stopped", 1'b0, 1'b0);
		wr(OFF_M4_MODE, 8'h12);
		rd(OFF_M4_MODE, 8'h12);
		wr(OFF_CNT_LOW, 8'h55);
		rd(OFF_CNT_LOW, 8'h55);
		// external pin clock: each settled rising edge counts once
		wr(OFF_MODE, 8'h04);
		wr(OFF_CTRL, 8'h01);
		repeat (4)
		begin
			extPin <= 1'b1;
			repeat (4) @(posedge clock);
			extPin <= 1'b0;
			repeat (4) @(posedge clock);
		end
		wr(OFF_CTRL, 8'h00);
		rd(OFF_CNT_LOW, 8'h59);
		// idle halt stops the counter only while the core idles
		wr(OFF_MODE, 8'h80);
		wr(OFF_CTRL, 8'h01);
		idle <= 1'b1;
		lvl("idle halted", 1'b0, 1'b0);
		idle <= 1'b0;
		lvl("idle resumed", 1'b0, 1'b1);
		wr(OFF_CTRL, 8'h00);
		$display("test release done");
		// service: slow clock keeps the high byte still meanwhile
		rnd = lfsrNext(rnd);
		wr(OFF_CNT_HIGH, 8'h20);
		wr(OFF_CNT_LOW, 8'h00);
		wr(OFF_M4_LOW, rnd[7:0]);
		wr(OFF_MODE, 8'h40);
		rd(OFF_M4_MODE, SW_TIMER_MODE);
		wr(OFF_M4_HIGH, rnd[15:8]);
		rd(OFF_M4_HIGH, 8'h20 + rnd[7:0]);
		wr(OFF_CNT_HIGH, 8'h77);
		rd(OFF_CNT_HIGH, 8'h20);
		wr(OFF_CNT_LOW, 8'h99);
		$display("test service done");
		// match fires the reset request and the interrupt
		wr(OFF_MODE, 8'h06);
		wr(OFF_CNT_HIGH, 8'h00);
		wr(OFF_CNT_LOW, 8'h00);
		wr(OFF_M4_HIGH, 8'h01);
		wr(OFF_STATUS, 8'h07);
		wr(OFF_MASK, 8'h02);
		wr(OFF_MODE, 8'h46);
		repeat (400) @(posedge clock);
		check("fires", fires, 1);
		lvl("irq", 1'b1, 1'b1);
		wr(OFF_MASK, 8'h00);
		lvl("irq masked", 1'b1, 1'b0);
		wr(OFF_MASK, 8'h02);
		wr(OFF_STATUS, 8'h02);
		lvl("irq cleared", 1'b1, 1'b0);
		$display("test fire done");
		// a second reset brings the watchdog back armed
		rst_n <= 1'b0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		rd(OFF_MODE, 8'h40);
		rd(OFF_M4_MODE, SW_TIMER_MODE);
		$display("test reset done");
		tally_and_finish();
	end
endmodule : tb_top
